// File: src/itx_pkg.sv
// Package for the integer trap, exclusive OR and swap execute unit.
// Assumes a 32-bit datapath with a decoded operation code from the pipeline.
package itx_pkg;

    localparam int unsigned DATA_W    = 32;
    localparam int unsigned IMM_W     = 16;
    localparam int unsigned REG_SEL_W = 5;
    localparam int unsigned SET_SEL_W = 4;
    localparam int unsigned REL_W     = 4;

    // Lowest architecture release that has the shadow write and byte swap.
    localparam logic [3:0] MIN_RELEASE = 4'h2;

    localparam logic [31:0] RESULT_RST = 32'h0000_0000;

    typedef enum logic [2:0]
    {
        ITX_OP_NONE,
        ITX_OP_TRAP_LTU,
        ITX_OP_TRAP_NE,
        ITX_OP_TRAP_NE_IMM,
        ITX_OP_XOR_REG,
        ITX_OP_XOR_IMM,
        ITX_OP_SWAP_HALVES,
        ITX_OP_WR_SHADOW
    } itx_op_e;

endpackage

// File: src/itx_compare.sv
// Compare stage for the trap operations of the execute unit.
// Assumes operands are stable for the whole cycle the operation is valid.
`timescale 1ns/10ps
`default_nettype none

module itx_compare
(
    // Operands
    input  wire logic [31:0] opnd_a,
    input  wire logic [31:0] opnd_b,
    input  wire logic [15:0] imm,
    // Compare results
    output logic             a_lt_b_unsigned,
    output logic             a_ne_b,
    output logic             a_ne_imm
);

    logic [31:0] imm_sext;

    // A 33-bit compare with a zero on top keeps both operands unsigned.
    assign a_lt_b_unsigned = {1'b0, opnd_a} < {1'b0, opnd_b};  // RQ1
    assign a_ne_b          = opnd_a != opnd_b;                 // RQ3
    assign imm_sext        = {{16{imm[15]}}, imm};             // RQ4
    assign a_ne_imm        = opnd_a != imm_sext;               // RQ4

endmodule

`default_nettype wire

// File: src/itx_exec.sv
// Execute-stage unit for traps, exclusive OR, byte swap and shadow writes.
// Assumes the pipeline presents one decoded operation per valid cycle and
// that the register file takes results the next cycle and the exception unit in the same cycle.
`timescale 1ns/10ps
`default_nettype none

// Function
// (RQ1) trap_less_unsigned traps if source_reg_a < source_reg_b unsigned.
// (RQ2) The code field of a register-compare trap word never affects the trap.
// (RQ3) trap_not_equal traps when source_reg_a differs from source_reg_b.
// (RQ4) trap_not_equal_imm traps if source_reg_a != sign-extended imm.
// (RQ5) write_previous_shadow_gpr copies source_reg_a to a shadow entry.
// (RQ6) Shadow write and swap raise reserved instruction below release 2.
// (RQ7) swap_bytes_in_halves writes bytes 23..16, 31..24, 7..0, 15..8.
// (RQ8) Register XOR writes source_reg_a ^ source_reg_b with no exception.
// (RQ9) exclusive_or_immediate xors source_reg_a with zero-extended imm.
// (RQ10) A trap is signalled in its execute cycle and commits no write.
// (RQ11) Shadow write without privileged access raises coprocessor unusable.
module itx_exec
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                nrst,
    // Decoded operation
    input  wire logic                op_valid,
    input  wire itx_pkg::itx_op_e    op_code,
    input  wire logic [31:0]         source_reg_a,
    input  wire logic [31:0]         source_reg_b,
    input  wire logic [15:0]         imm,
    input  wire logic [9:0]          trap_code,
    input  wire logic [4:0]          target_reg,
    input  wire logic [4:0]          dest_reg,
    input  wire logic [3:0]          previous_shadow_set_field,
    // Core configuration
    input  wire logic [3:0]          arch_release,
    input  wire logic                priv_cop_enabled,
    // Exception requests, same cycle
    output logic                     trap_req,
    output logic                     resv_instr_req,
    output logic                     cop_unusable_req,
    // Register file write
    output logic                     gpr_we_q,
    output logic [4:0]               gpr_waddr_q,
    output logic [31:0]              gpr_wdata_q,
    // Shadow register file write
    output logic                     shadow_we_q,
    output logic [3:0]               shadow_set_q,
    output logic [4:0]               shadow_reg_q,
    output logic [31:0]              shadow_wdata_q
);

    logic        lt_u;
    logic        ne_reg;
    logic        ne_imm;
    logic        new_op;
    logic        trap_hit;
    logic        gpr_we_d;
    logic [4:0]  gpr_waddr_d;
    logic [31:0] gpr_wdata_d;
    logic        shadow_we_d;
    logic [3:0]  shadow_set_d;
    logic [4:0]  shadow_reg_d;
    logic [31:0] shadow_wdata_d;
    logic        ignored_code;

    function automatic logic [31:0] swap_halves(input logic [31:0] v);
        swap_halves = {v[23:16], v[31:24], v[7:0], v[15:8]};
    endfunction

    itx_compare itx_compare_inst
    (
        .opnd_a          (source_reg_a),
        .opnd_b          (source_reg_b),
        .imm             (imm),
        .a_lt_b_unsigned (lt_u),
        .a_ne_b          (ne_reg),
        .a_ne_imm        (ne_imm)
    );

    // The code field is accepted only so that the port exists; it is left
    // out of every compare on purpose.
    assign ignored_code = |trap_code;  // RQ2

    assign new_op = (arch_release >= itx_pkg::MIN_RELEASE);

    always_comb
    begin
        trap_hit = 1'b0;
        if (op_valid)
        begin
            case (op_code)
                itx_pkg::ITX_OP_TRAP_LTU:    trap_hit = lt_u;    // RQ1
                itx_pkg::ITX_OP_TRAP_NE:     trap_hit = ne_reg;  // RQ3
                itx_pkg::ITX_OP_TRAP_NE_IMM: trap_hit = ne_imm;  // RQ4
                default:                     trap_hit = 1'b0;
            endcase
        end
    end

    // Exceptions go out combinationally so the exception unit sees them in
    // the execute cycle itself.
    always_comb
    begin
        trap_req         = trap_hit;  // RQ10
        resv_instr_req   = 1'b0;
        cop_unusable_req = 1'b0;
        if (op_valid && !new_op &&
            (op_code == itx_pkg::ITX_OP_WR_SHADOW ||
             op_code == itx_pkg::ITX_OP_SWAP_HALVES))
        begin
            resv_instr_req = 1'b1;  // RQ6
        end
        // Reserved instruction takes priority over the privilege check.
        if (op_valid && new_op && !priv_cop_enabled &&
            op_code == itx_pkg::ITX_OP_WR_SHADOW)
        begin
            cop_unusable_req = 1'b1;  // RQ11
        end
    end

    always_comb
    begin
        gpr_we_d       = 1'b0;
        gpr_waddr_d    = gpr_waddr_q;
        gpr_wdata_d    = gpr_wdata_q;
        shadow_we_d    = 1'b0;
        shadow_set_d   = shadow_set_q;
        shadow_reg_d   = shadow_reg_q;
        shadow_wdata_d = shadow_wdata_q;
        if (op_valid && !trap_hit)  // RQ10
        begin
            case (op_code)
                itx_pkg::ITX_OP_XOR_REG:
                begin
                    gpr_we_d    = 1'b1;
                    gpr_waddr_d = dest_reg;
                    gpr_wdata_d = source_reg_a ^ source_reg_b;  // RQ8
                end
                itx_pkg::ITX_OP_XOR_IMM:
                begin
                    gpr_we_d    = 1'b1;
                    gpr_waddr_d = target_reg;
                    gpr_wdata_d = source_reg_a ^ {16'h0000, imm};  // RQ9
                end
                itx_pkg::ITX_OP_SWAP_HALVES:
                begin
                    if (new_op)  // RQ6
                    begin
                        gpr_we_d    = 1'b1;
                        gpr_waddr_d = target_reg;
                        gpr_wdata_d = swap_halves(source_reg_a);  // RQ7
                    end
                end
                itx_pkg::ITX_OP_WR_SHADOW:
                begin
                    if (new_op && priv_cop_enabled)  // RQ11
                    begin
                        shadow_we_d    = 1'b1;  // RQ5
                        shadow_set_d   = previous_shadow_set_field;
                        shadow_reg_d   = target_reg;
                        shadow_wdata_d = source_reg_a;
                    end
                end
                default: gpr_we_d = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            gpr_we_q       <= 1'b0;
            gpr_waddr_q    <= 5'h00;
            gpr_wdata_q    <= itx_pkg::RESULT_RST;
            shadow_we_q    <= 1'b0;
            shadow_set_q   <= 4'h0;
            shadow_reg_q   <= 5'h00;
            shadow_wdata_q <= itx_pkg::RESULT_RST;
        end
        else
        begin
            gpr_we_q       <= gpr_we_d;
            gpr_waddr_q    <= gpr_waddr_d;
            gpr_wdata_q    <= gpr_wdata_d;
            shadow_we_q    <= shadow_we_d;
            shadow_set_q   <= shadow_set_d;
            shadow_reg_q   <= shadow_reg_d;
            shadow_wdata_q <= shadow_wdata_d;
        end
    end

    property p_ltu_trap;
        @(posedge clk) disable iff (!nrst)
        (op_valid && op_code == itx_pkg::ITX_OP_TRAP_LTU)
            |-> (trap_req == ({1'b0, source_reg_a} < {1'b0, source_reg_b}));
    endproperty
    a_ltu_trap: assert property (p_ltu_trap) else $error("ltu wrong"); // RQ1

    property p_code_ignored;
        @(posedge clk) disable iff (!nrst)
        (op_valid && op_code == itx_pkg::ITX_OP_TRAP_NE && ignored_code)
            |-> (trap_req == (source_reg_a != source_reg_b));
    endproperty
    a_code_ignored: assert property (p_code_ignored) // RQ2
        else $error("code used");

    property p_ne_trap;
        @(posedge clk) disable iff (!nrst)
        (op_valid && op_code == itx_pkg::ITX_OP_TRAP_NE)
            |-> (trap_req == (source_reg_a != source_reg_b));
    endproperty
    a_ne_trap: assert property (p_ne_trap) else $error("ne trap wrong"); // RQ3

    property p_nei_trap;
        @(posedge clk) disable iff (!nrst)
        (op_valid && op_code == itx_pkg::ITX_OP_TRAP_NE_IMM)
            |-> (trap_req == (source_reg_a != {{16{imm[15]}}, imm}));
    endproperty
    a_nei_trap: assert property (p_nei_trap) else $error("nei wrong"); // RQ4

    property p_shadow;
        @(posedge clk) disable iff (!nrst)
        (op_valid && op_code == itx_pkg::ITX_OP_WR_SHADOW && new_op &&
         priv_cop_enabled)
            |=> (shadow_we_q && shadow_wdata_q == $past(source_reg_a) &&
                 shadow_set_q == $past(previous_shadow_set_field));
    endproperty
    a_shadow: assert property (p_shadow) else $error("shadow lost"); // RQ5

    property p_resv;
        @(posedge clk) disable iff (!nrst)
        (op_valid && arch_release < itx_pkg::MIN_RELEASE &&
         (op_code == itx_pkg::ITX_OP_SWAP_HALVES ||
          op_code == itx_pkg::ITX_OP_WR_SHADOW))
            |-> resv_instr_req ##1 (!gpr_we_q && !shadow_we_q);
    endproperty
    a_resv: assert property (p_resv) else $error("release missed"); // RQ6

    property p_swap;
        @(posedge clk) disable iff (!nrst)
        (op_valid && new_op && op_code == itx_pkg::ITX_OP_SWAP_HALVES)
            |=> (gpr_we_q && gpr_wdata_q[31:24] == $past(source_reg_a[23:16])
                 && gpr_wdata_q[7:0] == $past(source_reg_a[15:8]));
    endproperty
    a_swap: assert property (p_swap) else $error("swap bytes wrong"); // RQ7

    property p_xor;
        @(posedge clk) disable iff (!nrst)
        (op_valid && op_code == itx_pkg::ITX_OP_XOR_REG)
            |=> (gpr_we_q && gpr_waddr_q == $past(dest_reg) &&
                 gpr_wdata_q == ($past(source_reg_a) ^ $past(source_reg_b)));
    endproperty
    a_xor: assert property (p_xor) else $error("xor wrong"); // RQ8

    property p_exclusive_or_immediate;
        @(posedge clk) disable iff (!nrst)
        (op_valid && op_code == itx_pkg::ITX_OP_XOR_IMM)
            |-> !trap_req && !resv_instr_req ##1
                (gpr_wdata_q[31:16] == $past(source_reg_a[31:16]));
    endproperty
    a_exclusive_or_immediate: assert property (p_exclusive_or_immediate) else $error("exclusive_or_immediate wrong"); // RQ9

    property p_no_commit;
        @(posedge clk) disable iff (!nrst)
        trap_req |=> !gpr_we_q && !shadow_we_q;
    endproperty
    a_no_commit: assert property (p_no_commit) // RQ10
        else $error("trap committed");

    property p_cpu;
        @(posedge clk) disable iff (!nrst)
        (op_valid && new_op && !priv_cop_enabled &&
         op_code == itx_pkg::ITX_OP_WR_SHADOW)
            |-> cop_unusable_req ##1 !shadow_we_q;
    endproperty
    a_cpu: assert property (p_cpu) else $error("privilege missed"); // RQ11

    c_trap:   cover property (@(posedge clk) trap_req);
    c_shadow: cover property (@(posedge clk) shadow_we_q);
    c_swap:   cover property (@(posedge clk)
        op_valid && op_code == itx_pkg::ITX_OP_SWAP_HALVES ##1 gpr_we_q);

endmodule

`default_nettype wire

// File: bench/itx_regfile_model.sv
// Register file and shadow register file that take the unit's writes.
// Assumes write strobes are single-cycle pulses seen at the rising edge.
`timescale 1ns/10ps
`default_nettype none

module itx_regfile_model
(
    // Clock
    input  wire logic        clk,
    // Register file write
    input  wire logic        gpr_we,
    input  wire logic [4:0]  gpr_waddr,
    input  wire logic [31:0] gpr_wdata,
    // Shadow register file write
    input  wire logic        shadow_we,
    input  wire logic [3:0]  shadow_set,
    input  wire logic [4:0]  shadow_reg,
    input  wire logic [31:0] shadow_wdata
);
    logic [31:0] gpr [32];
    logic [31:0] shadow_mem [16][32];
    int          n_gpr = 0;
    int          n_shadow = 0;

    always @(posedge clk)
    begin
        if (gpr_we === 1'b1)
        begin
            gpr[gpr_waddr] <= gpr_wdata;
            n_gpr <= n_gpr + 1;
        end
        if (shadow_we === 1'b1)
        begin
            shadow_mem[shadow_set][shadow_reg] <= shadow_wdata;
            n_shadow <= n_shadow + 1;
        end
    end
endmodule

`default_nettype wire

// File: bench/integer_trap_xor_swap_unit_test.sv
// Self-checking bench for the trap, exclusive OR and swap unit.
// Assumes the unit answers exceptions at once and writes one cycle later.
`timescale 1ns/10ps
`default_nettype none

module integer_trap_xor_swap_unit_test;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic op_valid = 1'b0;
    itx_pkg::itx_op_e op_code = itx_pkg::ITX_OP_NONE;
    logic [31:0] source_reg_a = 32'h0;
    logic [31:0] source_reg_b = 32'h0;
    logic [15:0] imm = 16'h0;
    logic [9:0] trap_code = 10'h0;
    logic [4:0] target_reg = 5'h0b;
    logic [4:0] dest_reg = 5'h15;
    logic [3:0] previous_shadow_set_field = 4'h9;
    logic [3:0] arch_release = 4'h2;
    logic priv_cop_enabled = 1'b1;
    logic trap_req, resv_instr_req, cop_unusable_req;
    logic gpr_we_q, shadow_we_q;
    logic [4:0] gpr_waddr_q, shadow_reg_q;
    logic [31:0] gpr_wdata_q, shadow_wdata_q;
    logic [3:0] shadow_set_q;
    int errors = 0;
    int n_checks = 0;

    always #5 clk = ~clk;

    itx_exec itx_exec_inst (.clk(clk), .nrst(nrst), .op_valid(op_valid),
        .op_code(op_code), .source_reg_a(source_reg_a),
        .source_reg_b(source_reg_b), .imm(imm), .trap_code(trap_code),
        .target_reg(target_reg), .dest_reg(dest_reg),
        .previous_shadow_set_field(previous_shadow_set_field),
        .arch_release(arch_release), .priv_cop_enabled(priv_cop_enabled),
        .trap_req(trap_req), .resv_instr_req(resv_instr_req),
        .cop_unusable_req(cop_unusable_req), .gpr_we_q(gpr_we_q),
        .gpr_waddr_q(gpr_waddr_q), .gpr_wdata_q(gpr_wdata_q),
        .shadow_we_q(shadow_we_q), .shadow_set_q(shadow_set_q),
        .shadow_reg_q(shadow_reg_q), .shadow_wdata_q(shadow_wdata_q));

    itx_regfile_model itx_regfile_model_inst (.clk(clk), .gpr_we(gpr_we_q),
        .gpr_waddr(gpr_waddr_q), .gpr_wdata(gpr_wdata_q),
        .shadow_we(shadow_we_q), .shadow_set(shadow_set_q),
        .shadow_reg(shadow_reg_q), .shadow_wdata(shadow_wdata_q));

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask

    // Exceptions are {trap, reserved, unusable}; called at a falling edge.
    task automatic op(input itx_pkg::itx_op_e o, input logic [31:0] a, b,
        input logic [15:0] im, input logic [2:0] exc, input logic gw, sw,
        input logic [31:0] d);
        op_valid = 1'b1;
        op_code = o;
        source_reg_a = a;
        source_reg_b = b;
        imm = im;
        trap_code = im[9:0] ^ a[9:0];
        #1;
        chk("exceptions", {29'h0, exc},
            {29'h0, trap_req, resv_instr_req, cop_unusable_req});
        @(negedge clk);
        chk("gpr_we", {31'h0, gw}, {31'h0, gpr_we_q});
        chk("shadow_we", {31'h0, sw}, {31'h0, shadow_we_q});
        if (gw)
        begin
            chk("gpr_waddr", (o == itx_pkg::ITX_OP_XOR_REG) ? dest_reg
                : target_reg, gpr_waddr_q);
            chk("gpr_wdata", d, gpr_wdata_q);
        end
        if (sw)
        begin
            chk("shadow_addr", {23'h0, previous_shadow_set_field, target_reg},
                {23'h0, shadow_set_q, shadow_reg_q});
            chk("shadow_wdata", d, shadow_wdata_q);
        end
    endtask

    task automatic idle(input string nm);
        op_valid = 1'b0;
        @(negedge clk);
        $display("test %s done", nm);
    endtask

    task automatic t_traps;
        op(itx_pkg::ITX_OP_TRAP_LTU, 1, 2, 16'h0, 3'b100, 0, 0, 0);
        op(itx_pkg::ITX_OP_TRAP_LTU, 1, 2, 16'h3ff, 3'b100, 0, 0, 0);
        op(itx_pkg::ITX_OP_TRAP_LTU, 32'h8000_0000, 1, 0, 0, 0, 0, 0);
        op(itx_pkg::ITX_OP_TRAP_LTU, 1, 32'h8000_0000, 0, 4, 0, 0, 0);
        op(itx_pkg::ITX_OP_TRAP_LTU, 5, 5, 16'h155, 0, 0, 0, 0);
        op(itx_pkg::ITX_OP_TRAP_NE, 7, 7, 16'h2aa, 0, 0, 0, 0);
        op(itx_pkg::ITX_OP_TRAP_NE, 32'h8000_0007, 7, 0, 4, 0, 0, 0);
        op(itx_pkg::ITX_OP_TRAP_NE_IMM, 32'hffff_8000, 0, 16'h8000,
            0, 0, 0, 0);
        op(itx_pkg::ITX_OP_TRAP_NE_IMM, 32'h0000_8000, 0, 16'h8000,
            4, 0, 0, 0);
        op(itx_pkg::ITX_OP_TRAP_NE_IMM, 32'h0000_0123, 0, 16'h0123,
            0, 0, 0, 0);
        op(itx_pkg::ITX_OP_NONE, 1, 2, 16'h0, 0, 0, 0, 0);
        idle("traps");
    endtask

    task automatic t_writes;
        op(itx_pkg::ITX_OP_XOR_REG, 32'hf0f0_1234, 32'h0ff0_4321, 0,
            0, 1, 0, 32'hff00_5115);
        op(itx_pkg::ITX_OP_XOR_IMM, 32'h1234_5678, 0, 16'h8001,
            0, 1, 0, 32'h1234_d679);
        op(itx_pkg::ITX_OP_SWAP_HALVES, 32'h1122_3344, 0, 0,
            0, 1, 0, 32'h2211_4433);
        op(itx_pkg::ITX_OP_WR_SHADOW, 32'hcafe_0001, 0, 0,
            0, 0, 1, 32'hcafe_0001);
        previous_shadow_set_field = 4'h6;
        target_reg = 5'h1e;
        op(itx_pkg::ITX_OP_WR_SHADOW, 32'h5eed_0006, 0, 0,
            0, 0, 1, 32'h5eed_0006);
        previous_shadow_set_field = 4'h9;
        target_reg = 5'h0b;
        priv_cop_enabled = 1'b0;
        op(itx_pkg::ITX_OP_WR_SHADOW, 32'h0bad_0002, 0, 0,
            1, 0, 0, 0);
        arch_release = 4'h1;
        op(itx_pkg::ITX_OP_WR_SHADOW, 32'h0bad_0003, 0, 0,
            2, 0, 0, 0);
        priv_cop_enabled = 1'b1;
        op(itx_pkg::ITX_OP_SWAP_HALVES, 32'h0bad_0004, 0, 0,
            2, 0, 0, 0);
        op(itx_pkg::ITX_OP_WR_SHADOW, 32'h0bad_0005, 0, 0,
            2, 0, 0, 0);
        arch_release = 4'hf;
        op(itx_pkg::ITX_OP_SWAP_HALVES, 32'ha1b2_c3d4, 0, 0,
            0, 1, 0, 32'hb2a1_d4c3);
        idle("writes");
        chk("model_writes", 4, itx_regfile_model_inst.n_gpr);
        chk("model_shadow", 2, itx_regfile_model_inst.n_shadow);
        chk("model_shadow_mem", 32'hcafe_0001,
            itx_regfile_model_inst.shadow_mem[9][11]);
        chk("model_shadow_mem", 32'h5eed_0006,
            itx_regfile_model_inst.shadow_mem[6][30]);
    endtask

    // A second reset in mid-run must clear held write data.
    task automatic t_reset;
        nrst = 1'b0;
        @(negedge clk);
        chk("wdata_reset", 0, gpr_wdata_q);
        chk("swdata_reset", 0, shadow_wdata_q);
        nrst = 1'b1;
        @(negedge clk);
        op(itx_pkg::ITX_OP_XOR_REG, 32'h5, 32'h3, 0, 0, 1, 0, 32'h6);
        idle("reset");
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(negedge clk);
        chk("we_in_reset", 0, {gpr_we_q, shadow_we_q});
        nrst = 1'b1;
        @(negedge clk);
        t_traps();
        t_writes();
        t_reset();
        summarize();
    end

    // The tests need under a hundred cycles; this is a generous margin.
    initial
    begin
        #20000;
        errors++;
        summarize();
    end
endmodule

`default_nettype wire
